// *** hdl/rsc_consts.svh ***
// Constants for the reset source controller
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ------------------------------------------------------------
// Register address and field positions
// ------------------------------------------------------------
`define RSC_SRC_ADDR      8'hef
`define RSC_BIT_RTC       7
`define RSC_BIT_FLASH     6
`define RSC_BIT_CMP       5
`define RSC_BIT_SW        4
`define RSC_BIT_WDT       3
`define RSC_BIT_MCD       2
`define RSC_BIT_PWR       1
`define RSC_BIT_PIN       0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RSC_FLAGS_POR     8'h02
`define RSC_ZERO8         8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RSC_CLK_PERIOD_NS 100
`define RSC_MCD_TIME_NS   100000
`define RSC_MCD_CYC       ((`RSC_MCD_TIME_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_HOLD_CYC      8'h10
`define RSC_WDT_DIV       4'hc
`define RSC_WDT_MAX       16'hffff

`endif

// *** hdl/rsc_pkg.sv ***
// Types shared by the reset source controller modules
package rsc_pkg;

    typedef enum logic [1:0] {
        RSC_RUN  = 2'b00,
        RSC_HOLD = 2'b01,
        RSC_PIN  = 2'b10
    } rsc_state_t;

    typedef struct packed {
        rsc_state_t  st;
        logic [7:0]  hold;
        logic [7:0]  flags;
        logic        en_rtc;
        logic        en_cmp;
        logic        en_mcd;
        logic        en_pwr;
        logic        wdt_en;
        logic [10:0] mcd_cnt;
        logic [1:0]  pin_s;
        logic [1:0]  sup_s;
        logic [1:0]  cmp_s;
        logic [1:0]  slow_s;
        logic [1:0]  clk_s;
        logic        clk_prev;
        logic [7:0]  rdata;
        logic        rst_out;
    } rsc_ctl_t;

    typedef struct packed {
        logic [3:0]  div;
        logic [15:0] cnt;
        logic        fire;
    } rsc_wdt_t;

endpackage

// *** hdl/rsc_pkg_note.sv ***
// Empty compile unit intentionally omitted

// *** hdl/rsc_top.sv ***
// Reset source controller: collects reset causes and records the last one
//
// How it works
// - Watchdog restarts enabled, clock divided twelve
// - Watchdog overflow resets, sets bit three
// - Watchdog source gated off in low power
// - Internal resets never touch the reset pin
// - Flash write above lock byte resets
// - Code read above lock byte resets
// - Fetch above lock byte resets
// - Security-blocked flash access resets
// - Flash write with monitor off resets
// - Flash error reads one in bit six
// - Oscillator fail needs detector and slow clock
// - Alarm fires when enabled and values match
// - Bit seven enables clock alarm source, flags
// - Clock alarm source stays live in sleep
// - Writing bit four forces reset, flags it
// - Bit five enables comparator source, flags
// - Bit two enables clock loss detector, flags
// - Bit one enables supply source, flags power
// - Bit zero flags external pin reset
// - Read-modify-write keeps other enables intact
// - External pin low holds device in reset
// - Clock stalled over 100 us resets
`timescale 1ns/1ps
`include "rsc_consts.svh"

module rsc_top
    import rsc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Special function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // Pins and analog status
    input  wire logic        ext_reset_pin_n,
    input  wire logic        supply_ok,
    input  wire logic        supply_mon_on,
    input  wire logic        cmp_below,
    input  wire logic        cmp_wake_en,
    input  wire logic        system_clock_mon,
    input  wire logic        low_power,
    // Watchdog control from the counter array
    input  wire logic        wdt_disable,
    input  wire logic        wdt_service,
    // Clock alarm
    input  wire logic        osc_fail_det_en,
    input  wire logic        rtc_below_20khz,
    input  wire logic        alarm_en,
    input  wire logic [31:0] rtc_timer,
    input  wire logic [31:0] alarm_compare_registers,
    // Flash access monitoring
    input  wire logic [15:0] lock_addr,
    input  wire logic        program_store_write_enable,
    input  wire logic        external_data_move,
    input  wire logic [15:0] xdata_addr,
    input  wire logic        code_memory_read,
    input  wire logic [15:0] code_addr,
    input  wire logic        fetch,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        security_block,
    output logic             flash_write_grant,
    // Reset to the rest of the system
    output logic             sys_rst_n_out
);

    rsc_ctl_t c_reg;
    rsc_ctl_t c_next;

    logic       wdt_timeout;
    logic       wdt_restart;
    logic       wdt_run;
    logic       wr_src;
    logic       wr_attempt;
    logic       fe_lock;
    logic       fe_code;
    logic       fe_fetch;
    logic       fe_vdm;
    logic       flash_err;
    logic       alarm_hit;
    logic       osc_fail;
    logic       rtc_event;
    logic       cmp_event;
    logic       pwr_event;
    logic       mcd_event;
    logic       pin_low;
    logic       clk_edge;
    logic [7:0] cause;
    logic [7:0] cause_one;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic above_lock(input logic [15:0] a,
                                        input logic [15:0] lock);
        above_lock = (a > lock);
    endfunction

    // Only one register sits behind the port, at one address
    function automatic logic is_src(input logic [7:0] a);
        is_src = (a == `RSC_SRC_ADDR);
    endfunction

    // Lowest bit wins: pin, power, clock loss, watchdog,
    // software, comparator, flash, alarm.
    function automatic logic [7:0] pick_cause(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 8'h00;
                r[i] = 1'b1;
            end
        end
        pick_cause = r;
    endfunction

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // The enable bit itself is kept across low power; only its effect
    // is gated, so the previous setting returns on wake-up.
    assign wdt_run     = c_reg.wdt_en && !low_power;
    // Held at zero while in reset so the count starts fresh on release
    assign wdt_restart = (c_reg.st != RSC_RUN);

    rsc_watchdog u_wdt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .restart (wdt_restart),
        .run     (wdt_run),
        .service (wdt_service),
        .timeout (wdt_timeout)
    );

    // ------------------------------------------------------------
    // Flash access checks
    // ------------------------------------------------------------
    assign wr_attempt = program_store_write_enable && external_data_move;
    assign fe_lock    = wr_attempt && above_lock(xdata_addr, lock_addr);
    assign fe_code    = code_memory_read &&
                        above_lock(code_addr, lock_addr);
    assign fe_fetch   = fetch && above_lock(fetch_addr, lock_addr);
    assign fe_vdm     = wr_attempt && !supply_mon_on;
    // Blocked accesses are refused here and turned into a reset
    assign flash_err  = fe_lock || fe_code || fe_fetch ||
                        security_block || fe_vdm;

    // Write goes through only when no violation stops it
    assign flash_write_grant = wr_attempt && !flash_err &&
                               (c_reg.st == RSC_RUN);

    // ------------------------------------------------------------
    // Other reset sources
    // ------------------------------------------------------------
    // A match is a level: it resets again on each re-enable until software moves it
    assign alarm_hit = alarm_en &&
                       (rtc_timer == alarm_compare_registers);
    assign osc_fail  = osc_fail_det_en && c_reg.slow_s[1];
    // Alarm source is not gated by low power
    assign rtc_event = c_reg.en_rtc && (alarm_hit || osc_fail);

    // Comparator survives low power only when armed as wake source
    assign cmp_event = c_reg.en_cmp && c_reg.cmp_s[1] &&
                       (!low_power || cmp_wake_en);
    assign pwr_event = c_reg.en_pwr && !c_reg.sup_s[1];
    assign mcd_event = c_reg.en_mcd && !low_power &&
                       (c_reg.mcd_cnt >= 11'(`RSC_MCD_CYC));
    assign pin_low   = !c_reg.pin_s[1];
    assign clk_edge  = c_reg.clk_s[1] ^ c_reg.clk_prev;

    assign wr_src = sfr_wr && is_src(sfr_addr);

    // ------------------------------------------------------------
    // Cause collection
    // ------------------------------------------------------------
    // Every source is sampled at once; the priority pick below keeps
    // the recorded flag one-hot even when two causes coincide.
    always_comb begin
        cause = 8'h00;
        cause[`RSC_BIT_PIN]   = pin_low;
        cause[`RSC_BIT_PWR]   = pwr_event;
        cause[`RSC_BIT_MCD]   = mcd_event;
        cause[`RSC_BIT_CMP]   = cmp_event;
        cause[`RSC_BIT_WDT]   = wdt_timeout;
        cause[`RSC_BIT_SW]    = wr_src && sfr_wdata[`RSC_BIT_SW];
        cause[`RSC_BIT_FLASH] = flash_err;
        cause[`RSC_BIT_RTC]   = rtc_event;
    end

    assign cause_one = pick_cause(cause);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        c_next = c_reg;

        // Two-stage synchronisers for pin, supply, comparator, slow clock and watched clock; only the
        // second stage feeds logic, so a metastable first stage never
        // reaches the decisions below.
        c_next.pin_s    = {c_reg.pin_s[0], ext_reset_pin_n};
        c_next.sup_s    = {c_reg.sup_s[0], supply_ok};
        c_next.cmp_s    = {c_reg.cmp_s[0], cmp_below};
        c_next.slow_s   = {c_reg.slow_s[0], rtc_below_20khz};
        c_next.clk_s    = {c_reg.clk_s[0], system_clock_mon};
        c_next.clk_prev = c_reg.clk_s[1];

        // Clock loss timer: restarted by any edge of the watched clock
        // and saturating, so a long stall cannot wrap round and hide.
        if (clk_edge || !c_reg.en_mcd || low_power) begin
            c_next.mcd_cnt = 11'h000;
        end else if (c_reg.mcd_cnt < 11'(`RSC_MCD_CYC)) begin
            c_next.mcd_cnt = c_reg.mcd_cnt + 11'h001;
        end

        // Software may switch the watchdog off; any reset turns it on
        if (wdt_disable) begin
            c_next.wdt_en = 1'b0;
        end

        // --------------------------------------------------------
        // Reset sequencing
        // --------------------------------------------------------
        case (c_reg.st)
            RSC_RUN: begin
                c_next.rst_out = 1'b0;
                if (cause != 8'h00) begin
                    // Only the winning cause is recorded
                    c_next.flags   = cause_one;
                    c_next.st      = RSC_HOLD;
                    c_next.hold    = `RSC_ZERO8;
                    c_next.rst_out = 1'b1;
                end else if (wr_src) begin
                    // Writes count only in run; a cause in that cycle wins
                    c_next.en_rtc = sfr_wdata[`RSC_BIT_RTC];
                    c_next.en_cmp = sfr_wdata[`RSC_BIT_CMP];
                    c_next.en_mcd = sfr_wdata[`RSC_BIT_MCD];
                    c_next.en_pwr = sfr_wdata[`RSC_BIT_PWR];
                end
            end
            RSC_HOLD: begin
                c_next.rst_out = 1'b1;
                // A pin or supply fault during the hold takes the flag
                if (pin_low) begin
                    c_next.flags = cause_one;
                    c_next.st    = RSC_PIN;
                end else if (pwr_event) begin
                    c_next.flags = cause_one;
                    // Restart the stretch so release waits for good supply
                    c_next.hold  = `RSC_ZERO8;
                end else if (c_reg.hold == `RSC_HOLD_CYC - 8'h01) begin
                    c_next.st      = RSC_RUN;
                    c_next.rst_out = 1'b0;
                    // Watchdog turns back on; alarm, comparator and clock loss enables fall back to off
                    c_next.wdt_en  = 1'b1;
                    c_next.en_rtc  = 1'b0;
                    c_next.en_cmp  = 1'b0;
                    c_next.en_mcd  = 1'b0;
                    c_next.mcd_cnt = 11'h000;
                end else begin
                    c_next.hold = c_reg.hold + 8'h01;
                end
            end
            RSC_PIN: begin
                // Held in reset for as long as the pin stays low,
                // then stretched once more by the full hold count
                c_next.rst_out = 1'b1;
                c_next.flags   = `RSC_ZERO8;
                c_next.flags[`RSC_BIT_PIN] = 1'b1;
                if (!pin_low) begin
                    c_next.st   = RSC_HOLD;
                    c_next.hold = `RSC_ZERO8;
                end
            end
            default: begin
                c_next.st      = RSC_HOLD;
                c_next.hold    = `RSC_ZERO8;
                c_next.rst_out = 1'b1;
            end
        endcase

        // --------------------------------------------------------
        // Register read path
        // --------------------------------------------------------
        // Read data: flags normally; enables on read-modify-write so
        // the write-back leaves other sources as they were.
        // The force bit reads zero there, so write-back never resets.
        c_next.rdata = `RSC_ZERO8;
        if (sfr_rd && is_src(sfr_addr)) begin
            if (sfr_rmw) begin
                c_next.rdata[`RSC_BIT_RTC] = c_reg.en_rtc;
                c_next.rdata[`RSC_BIT_CMP] = c_reg.en_cmp;
                c_next.rdata[`RSC_BIT_MCD] = c_reg.en_mcd;
                c_next.rdata[`RSC_BIT_PWR] = c_reg.en_pwr;
            end else begin
                c_next.rdata = c_reg.flags;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on leaves the supply source armed and reports the power
    // flag; the system reset is then stretched by the hold count.
    // Pin and supply synchronisers start at the idle high level to avoid a false cause.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            c_reg          <= '0;
            c_reg.st       <= RSC_HOLD;
            c_reg.flags    <= `RSC_FLAGS_POR;
            c_reg.en_pwr   <= 1'b1;
            c_reg.wdt_en   <= 1'b1;
            c_reg.pin_s    <= 2'b11;
            c_reg.sup_s    <= 2'b11;
            c_reg.rst_out  <= 1'b1;
        end else begin
            c_reg <= c_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The pin is input only here, so no internal cause can pull it.
    // The hold count keeps every internal reset a fixed minimum long.
    assign sys_rst_n_out = !c_reg.rst_out;
    assign sfr_rdata     = c_reg.rdata;

endmodule

// *** hdl/rsc_watchdog.sv ***
// Watchdog counter clocked by an enable at one twelfth of the clock
`timescale 1ns/1ps
`include "rsc_consts.svh"

module rsc_watchdog
    import rsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic restart,
    input  wire logic run,
    input  wire logic service,
    output logic      timeout
);

    rsc_wdt_t s_reg;
    rsc_wdt_t s_next;

    // ------------------------------------------------------------
    // Divide by twelve, then count ticks up to overflow
    // ------------------------------------------------------------
    always_comb begin
        s_next      = s_reg;
        s_next.fire = 1'b0;
        if (restart || service) begin
            s_next.div = 4'h0;
            s_next.cnt = 16'h0000;
        end else if (run) begin
            if (s_reg.div == `RSC_WDT_DIV - 4'h1) begin
                s_next.div = 4'h0;
                if (s_reg.cnt == `RSC_WDT_MAX) begin
                    s_next.cnt  = 16'h0000;
                    s_next.fire = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
            end else begin
                s_next.div = s_reg.div + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign timeout = s_reg.fire;

endmodule

// *** tb/rsc_monitor.sv ***
// Concurrent checks on the reset source controller ports
`timescale 1ns/1ps

module rsc_monitor (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic        sfr_rmw,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        ext_reset_pin_n,
    input wire logic        supply_mon_on,
    input wire logic [15:0] lock_addr,
    input wire logic        program_store_write_enable,
    input wire logic        external_data_move,
    input wire logic [15:0] xdata_addr,
    input wire logic        code_memory_read,
    input wire logic [15:0] code_addr,
    input wire logic        fetch,
    input wire logic [15:0] fetch_addr,
    input wire logic        security_block,
    input wire logic        flash_write_grant,
    input wire logic        sys_rst_n_out
);
    logic [7:0] low_cnt_reg;
    logic [7:0] low_cnt_next;
    logic       hit_ef;
    logic       xw_bad;

    assign hit_ef = sfr_addr == 8'hef;
    assign xw_bad = program_store_write_enable && external_data_move
                    && (xdata_addr > lock_addr);

    // ------------------------------------------------------------
    // Length of the current reset pulse, saturating
    // ------------------------------------------------------------
    always_comb begin
        low_cnt_next = sys_rst_n_out ? 8'h00
                     : low_cnt_reg + {7'h00, low_cnt_reg != 8'hff};
    end

    // Reset itself counts as a full hold, so seed at sixteen
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            low_cnt_reg <= 8'h10;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_SW_FORCE: assert property (
        sfr_wr && hit_ef && sfr_wdata[4] && sys_rst_n_out |=> !sys_rst_n_out)
        else $error("software force did not reset");
    AST_HOLD_LEN: assert property (
        $rose(sys_rst_n_out) |-> low_cnt_reg >= 8'h10)
        else $error("reset released too early");
    AST_PIN: assert property (
        !ext_reset_pin_n [*3] |=> !sys_rst_n_out)
        else $error("low pin did not reset");
    AST_XW_RST: assert property (
        xw_bad && sys_rst_n_out |=> !sys_rst_n_out)
        else $error("write above lock did not reset");
    AST_XW_GRANT: assert property (
        xw_bad |-> !flash_write_grant)
        else $error("write above lock granted");
    AST_MON_OFF: assert property (
        program_store_write_enable && external_data_move && !supply_mon_on
        |-> !flash_write_grant)
        else $error("write with monitor off granted");
    AST_CODE: assert property (
        code_memory_read && code_addr > lock_addr && sys_rst_n_out
        |=> !sys_rst_n_out)
        else $error("code read above lock did not reset");
    AST_FETCH: assert property (
        fetch && fetch_addr > lock_addr && sys_rst_n_out |=> !sys_rst_n_out)
        else $error("fetch above lock did not reset");
    AST_SEC: assert property (
        security_block && sys_rst_n_out |=> !sys_rst_n_out)
        else $error("blocked access did not reset");
    AST_RMW: assert property (
        sfr_rd && sfr_rmw && hit_ef |=> (sfr_rdata & 8'h59) == 8'h00)
        else $error("modify read shows flag bits");

    cover property ($rose(sys_rst_n_out));
    cover property (sfr_wr && hit_ef && sfr_wdata[4]);
    cover property (xw_bad && sys_rst_n_out);
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the reset source controller
`timescale 1ns/1ps

module tb;
    logic        ref_clk, rst_n, sfr_wr, sfr_rd, sfr_rmw, ext_reset_pin_n;
    logic        supply_ok, supply_mon_on, cmp_below, cmp_wake_en, fetch;
    logic        system_clock_mon, low_power, wdt_disable, wdt_service;
    logic        osc_fail_det_en, rtc_below_20khz, alarm_en, clk_go;
    logic        program_store_write_enable, external_data_move;
    logic        code_memory_read, security_block;
    logic        flash_write_grant, sys_rst_n_out;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [15:0] lock_addr, xdata_addr, code_addr, fetch_addr;
    logic [31:0] rtc_timer, alarm_compare_registers;
    int          err_total, checks;

    rsc_top dut (.*);

    always #50 ref_clk = ~ref_clk;

    // Watched clock toggles unless a scenario stalls it
    always @(posedge ref_clk) begin
        if (clk_go) system_clock_mon <= ~system_clock_mon;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic m,
                      input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rmw <= m;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        sfr_rmw <= 1'b0;
        #1 chk(sfr_rdata, exp);
    endtask

    task automatic wait_run();
        for (int i = 0; i < 300; i++) begin
            @(posedge ref_clk);
            #1;
            if (sys_rst_n_out === 1'b1) return;
        end
        chk({7'h00, sys_rst_n_out}, 8'h01);
        finish_test();
    endtask

    task automatic no_rst(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 chk({7'h00, sys_rst_n_out}, 8'h01);
        end
    endtask

    // Waits for a reset, withdraws every cause, then reads the flags
    task automatic expect_rst(input logic [7:0] fl);
        #1;
        for (int i = 0; i < 1200 && sys_rst_n_out !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({7'h00, sys_rst_n_out}, 8'h00);
        if (sys_rst_n_out !== 1'b0) finish_test();
        @(posedge ref_clk);
        {ext_reset_pin_n, supply_ok, supply_mon_on, clk_go} <= 4'hf;
        {cmp_below, alarm_en, osc_fail_det_en} <= 3'h0;
        {rtc_below_20khz, low_power} <= 2'h0;
        wait_run();
        rd(8'hef, 1'b0, fl);
    endtask

    // Kinds: 0 write, 1 code read, 2 fetch, 3 blocked access
    task automatic fl_hit(input int k, input logic [15:0] a, input logic g);
        @(posedge ref_clk);
        program_store_write_enable <= k == 0;
        external_data_move <= k == 0;
        code_memory_read <= k == 1;
        fetch <= k == 2;
        security_block <= k == 3;
        {xdata_addr, code_addr, fetch_addr} <= {a, a, a};
        #1 if (k == 0) chk({7'h00, flash_write_grant}, {7'h00, g});
        @(posedge ref_clk);
        {program_store_write_enable, external_data_move} <= 2'h0;
        {code_memory_read, fetch, security_block} <= 3'h0;
    endtask

    initial begin
        {ref_clk, rst_n, sfr_wr, sfr_rd, sfr_rmw, cmp_below, cmp_wake_en} = '0;
        {system_clock_mon, low_power, wdt_disable, wdt_service} = '0;
        {osc_fail_det_en, rtc_below_20khz, alarm_en, fetch} = '0;
        {program_store_write_enable, external_data_move} = '0;
        {code_memory_read, security_block, sfr_addr, sfr_wdata} = '0;
        {ext_reset_pin_n, supply_ok, supply_mon_on, clk_go} = 4'hf;
        {xdata_addr, code_addr, fetch_addr, rtc_timer} = '0;
        lock_addr = 16'h3fff;
        alarm_compare_registers = 32'h0000_1234;
        err_total = 0;
        checks = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_run();
        rd(8'hef, 1'b0, 8'h02);
        rd(8'hef, 1'b1, 8'h02);
        rd(8'hee, 1'b0, 8'h00);
        wr(8'hef, 8'ha6);
        rd(8'hef, 1'b1, 8'ha6);
        wr(8'hef, 8'h86);
        rd(8'hef, 1'b1, 8'h86);
        wr(8'hef, 8'h4b);
        rd(8'hef, 1'b0, 8'h02);
        wr(8'hef, 8'h12);
        expect_rst(8'h10);
        rd(8'hef, 1'b1, 8'h02);
        @(posedge ref_clk);
        ext_reset_pin_n <= 1'b0;
        expect_rst(8'h01);
        @(posedge ref_clk);
        cmp_below <= 1'b1;
        no_rst(6);
        wr(8'hef, 8'h22);
        expect_rst(8'h20);
        @(posedge ref_clk);
        {cmp_below, low_power} <= 2'b11;
        wr(8'hef, 8'h22);
        no_rst(6);
        @(posedge ref_clk);
        cmp_wake_en <= 1'b1;
        expect_rst(8'h20);
        @(posedge ref_clk);
        supply_ok <= 1'b0;
        expect_rst(8'h02);
        wr(8'hef, 8'h06);
        @(posedge ref_clk);
        {low_power, clk_go} <= 2'b10;
        no_rst(1100);
        @(posedge ref_clk);
        low_power <= 1'b0;
        expect_rst(8'h04);
        @(posedge ref_clk);
        {alarm_en, low_power} <= 2'b11;
        rtc_timer <= 32'h0000_1234;
        no_rst(6);
        wr(8'hef, 8'h82);
        expect_rst(8'h80);
        @(posedge ref_clk);
        rtc_below_20khz <= 1'b1;
        wr(8'hef, 8'h82);
        no_rst(6);
        @(posedge ref_clk);
        osc_fail_det_en <= 1'b1;
        expect_rst(8'h80);
        for (int k = 0; k < 3; k++) begin
            fl_hit(k, 16'h3fff, 1'b1);
            no_rst(4);
        end
        for (int k = 0; k < 4; k++) begin
            fl_hit(k, 16'h4000, 1'b0);
            expect_rst(8'h40);
        end
        @(posedge ref_clk);
        supply_mon_on <= 1'b0;
        fl_hit(0, 16'h0100, 1'b0);
        expect_rst(8'h40);
        @(posedge ref_clk);
        wdt_service <= 1'b1;
        @(posedge ref_clk);
        wdt_service <= 1'b0;
        no_rst(4);
        finish_test();
    end
endmodule

bind rsc_top rsc_monitor mon (.*);
